// >>> rx_irq_pkg.sv
// Package of register indices, field positions, resets and mode codes for the receiver interrupt mask logic.
package rx_irq_pkg;
    // Register indices of the two registers held here.
    localparam logic [7:0] mask_two_index = 8'h07;
    localparam logic [7:0] mode_one_index = 8'h08;
    // Field positions.
    localparam int slip_enable_bit = 0;
    localparam int lock_mode_low_bit = 4;
    localparam int crc_mode_lsb = 2;
    localparam int xfer_mode_lsb = 0;
    // Reset values.
    localparam logic [7:0] mask_two_reset = 8'h00;
    localparam logic [7:0] mode_one_reset = 8'h00;
    localparam logic [2:0] mask_one_reset = 3'h0;
    // Trigger mode codes.
    typedef enum logic [1:0] {
        mode_rise = 2'h0,
        mode_fall = 2'h1,
        mode_level = 2'h2,
        mode_reserved = 2'h3
    } trig_mode_t;
    // Register write request from the host port.
    typedef struct packed {
        logic wr;
        logic [7:0] index;
        logic [7:0] data;
    } reg_wr_t;
    // Event flag group: slip, lock loss, crc error, buffer transfer.
    typedef struct packed {
        logic slip;
        logic lock_loss;
        logic crc_error;
        logic xfer;
    } src_flags_t;
endpackage

// >>> rx_irq_mask_mode.sv
// Mask and trigger-mode logic for the receiver interrupt sources.
// How it works
// - Lock-loss mask bit, reset 0 blocks it.
// - CRC error mask bit, reset 0 blocks it.
// - Buffer transfer mask bit, reset 0 blocks.
// - Mask register two: slip enable bit 0.
// - Mode codes: rise, fall, level, reserved.
// - Mode register one field layout as documented.
module rx_irq_mask_mode
    import rx_irq_pkg::*;
#(
    // Width of every register held here; the field layout assumes eight bits.
    parameter int reg_width = 8
)
(
    // Clock, enable and reset.
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic rst_b,
    // Host register port.
    input wire reg_wr_t reg_wr,
    input wire logic [7:0] rd_index,
    output logic [7:0] rd_data,
    // Mask bits of the first mask register, held elsewhere in the map.
    input wire logic [2:0] mask_one,
    // Status flags from the receiver, same clock domain.
    input wire src_flags_t flags,
    // Gated per-source events and their combined output.
    output src_flags_t src_active,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration check.
    // The register layout below is fixed at eight bits per register.
    // A different width would move fields off their documented positions,
    // so any other value is refused before the logic is built.
    if (reg_width != 8) begin : g_width_check
        $error("reg_width must be 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage.
    // Both registers are written whole by the host, but only the bits that
    // carry a field keep their value; the rest always read back as zero.
    logic [7:0] mask_two; // Holds slip enable at bit 0.
    logic [7:0] mode_one; // Holds the three mode fields.
    src_flags_t flags_q; // Previous flags for edge detect.
    logic output_slip_irq_enable; // Slip enable taken from mask register two.
    logic lock_loss_mode_low; // Low bit of the lock-loss mode field.
    trig_mode_t crc_mode; // Trigger mode of the sub-code CRC error source.
    trig_mode_t xfer_mode; // Trigger mode of the buffer transfer source.
    trig_mode_t lock_mode; // Trigger mode of the lock-loss source.
    src_flags_t next_active; // Gated events that register on the next edge.

    // Mask register two write; only bit 0 is storage.
    // Writing the upper bits has no effect, so a host that writes all ones
    // still sees zeros there when it reads the register back.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_two <= mask_two_reset;
        end else if (clk_en && reg_wr.wr && reg_wr.index == mask_two_index) begin
            mask_two <= {7'h00, reg_wr.data[slip_enable_bit]};
        end
    end

    // Mode register one write; bits 7 to 5 are not held.
    // The reserved code 11 may be written and read back; it simply never
    // lets its source fire.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_one <= mode_one_reset;
        end else if (clk_en && reg_wr.wr && reg_wr.index == mode_one_index) begin
            mode_one <= {3'h0, reg_wr.data[4:0]};
        end
    end

    // Field extraction.
    assign output_slip_irq_enable = mask_two[slip_enable_bit];
    assign lock_loss_mode_low = mode_one[lock_mode_low_bit];
    assign crc_mode = trig_mode_t'(mode_one[crc_mode_lsb +: 2]);
    assign xfer_mode = trig_mode_t'(mode_one[xfer_mode_lsb +: 2]);
    // The lock-loss high mode bit lives outside this block; taken as zero.
    assign lock_mode = trig_mode_t'({1'b0, lock_loss_mode_low});

    // Read-back; unknown indices read zero.
    // The read path is combinational so the host sees a new value in the
    // cycle after the write edge, with no extra wait state.
    always_comb begin
        rd_data = 8'h00;
        if (rd_index == mask_two_index) begin
            rd_data = mask_two;
        end else if (rd_index == mode_one_index) begin
            rd_data = mode_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Previous flag values for edge detection.
    // The history clears to the idle level of the flags, so a flag that is
    // already low after reset gives no false edge.  A flag that is high
    // straight out of reset does count as a rising edge, by intent.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= '0;
        end else if (clk_en) begin
            flags_q <= flags;
        end
    end

    // Condition test for one source under its mode.
    // The same test serves every source, so all of them share one notion
    // of rising, falling and level activity.
    function automatic logic hit(input trig_mode_t m, input logic now, input logic was);
        logic r;
        r = 1'b0;
        unique case (m)
            mode_rise: r = now & ~was;
            mode_fall: r = ~now & was;
            mode_level: r = now;
            mode_reserved: r = 1'b0;
        endcase
        return r;
    endfunction

    // Mask gating; slip has no mode field and is treated as rising edge.
    always_comb begin
        next_active.lock_loss = mask_one[2] & hit(lock_mode, flags.lock_loss, flags_q.lock_loss);
        next_active.crc_error = mask_one[1] & hit(crc_mode, flags.crc_error, flags_q.crc_error);
        next_active.xfer = mask_one[0] & hit(xfer_mode, flags.xfer, flags_q.xfer);
        next_active.slip = output_slip_irq_enable & hit(mode_rise, flags.slip, flags_q.slip);
    end

    // Registered events and interrupt output.
    // Both come from flip-flops so the interrupt line never glitches while
    // flags or mode fields settle within a cycle.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_active <= '0;
            irq_out <= 1'b0;
        end else if (clk_en) begin
            src_active <= next_active;
            irq_out <= |next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_mask_blocks_lock: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && !mask_one[2] |=> !src_active.lock_loss) else $error("lock loss passed mask");
    a_mask_blocks_crc: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && !mask_one[1] |=> !src_active.crc_error) else $error("crc passed mask");
    a_mask_blocks_xfer: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && !mask_one[0] |=> !src_active.xfer) else $error("xfer passed mask");
    a_slip_readback: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && reg_wr.wr && reg_wr.index == mask_two_index && rd_index == mask_two_index
        |=> rd_index != mask_two_index || rd_data == {7'h00, $past(reg_wr.data[0])})
        else $error("slip readback wrong");
    a_rise_fires: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && mask_one[0] && xfer_mode == mode_rise && flags.xfer && !flags_q.xfer
        |=> src_active.xfer && irq_out) else $error("rising edge missed");
    a_fall_fires: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && mask_one[1] && crc_mode == mode_fall && !flags.crc_error && flags_q.crc_error
        |=> src_active.crc_error) else $error("falling edge missed");
    a_mode_layout: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && reg_wr.wr && reg_wr.index == mode_one_index
        |=> crc_mode == trig_mode_t'($past(reg_wr.data[3:2])) && lock_loss_mode_low == $past(reg_wr.data[4]))
        else $error("mode fields misplaced");
    a_level_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && mask_one[0] && xfer_mode == mode_level && flags.xfer |=> src_active.xfer)
        else $error("level not held");

    // A level source drops as soon as its flag goes low.
    a_level_drops: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && xfer_mode == mode_level && !flags.xfer |=> !src_active.xfer)
        else $error("level event outlived flag");

    // The reserved mode code must keep its source silent.
    a_reserved_silent: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && xfer_mode == mode_reserved |=> !src_active.xfer)
        else $error("reserved mode fired");

    // An enabled slip source fires on its rising edge.
    a_slip_rise_fires: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && output_slip_irq_enable && flags.slip && !flags_q.slip |=> src_active.slip)
        else $error("slip edge missed");

    // The slip source fires on nothing but a rising edge.
    a_slip_edge_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && !(flags.slip && !flags_q.slip) |=> !src_active.slip)
        else $error("slip fired without edge");

    // The upper bits of mask register two never hold a one.
    a_mask_two_upper: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mask_two[7:1] == 7'h00)
        else $error("mask two upper bits set");

    // The upper bits of mode register one never hold a one.
    a_mode_one_upper: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode_one[7:5] == 3'h0)
        else $error("mode one upper bits set");

    // A low clock enable freezes every register of the block.
    a_freeze_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !clk_en |=> $stable(mask_two) && $stable(mode_one) && $stable(src_active) && $stable(irq_out))
        else $error("state moved while frozen");

    // The interrupt output is the OR of the registered events.
    a_irq_combines: assert property (@(posedge ref_clk) disable iff (!rst_b)
        irq_out == (|src_active))
        else $error("interrupt not the OR of events");
endmodule

// >>> rx_irq_host.sv
// Host model that presents register writes and read indices to the mask block.
module rx_irq_host
    import rx_irq_pkg::*;
(
    // Register port towards the block.
    output reg_wr_t reg_wr,
    output logic [7:0] rd_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start idle so nothing is taken while reset is held.
    initial begin
        reg_wr = '0;
        rd_index = 8'h00;
    end
    // Present one write request, possibly idle, and a read index for the next rising edge.
    task automatic put(input logic wr, input logic [7:0] idx, input logic [7:0] dat, input logic [7:0] rdi);
        reg_wr = '{wr: wr, index: idx, data: dat};
        rd_index = rdi;
    endtask
endmodule

// >>> tb.sv
// Self-checking bench comparing the mask block against a behavioural model.
module tb;
    import rx_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, clk_en, rst_b, irq_out, m2;
    logic [2:0] mask_one;
    logic [4:0] m1;
    logic [3:0] prev, exp_src;
    logic [7:0] rd_data, rd_index, wi, ri;
    src_flags_t flags, src_active;
    reg_wr_t reg_wr;
    int fails, samples_checked, seed;
    ////////////////////////////////////////////////////////////////////////
    // The clock toggles every 4 ns, half of its 8 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    rx_irq_mask_mode i_dut (.ref_clk(ref_clk), .clk_en(clk_en), .rst_b(rst_b), .reg_wr(reg_wr),
        .rd_index(rd_index), .rd_data(rd_data), .mask_one(mask_one), .flags(flags),
        .src_active(src_active), .irq_out(irq_out));
    rx_irq_host i_host (.reg_wr(reg_wr), .rd_index(rd_index));
    ////////////////////////////////////////////////////////////////////////
    // One source fires when enabled and its selected condition holds; the reserved code never fires.
    function automatic logic fire(input logic c, input logic p, input logic en, input logic [1:0] md);
        return en && (md == 2'h0 ? c && !p : md == 2'h1 ? !c && p : md == 2'h2 ? c : 1'b0);
    endfunction
    // Expected read data; unused bits and other indices read zero.
    function automatic logic [7:0] rd_exp(input logic [7:0] idx);
        return idx == mask_two_index ? {7'h00, m2} : idx == mode_one_index ? {3'h0, m1} : 8'h00;
    endfunction
    // Model state follows each enabled edge using the values held before it.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            m2 = 1'b0;
            m1 = 5'h00;
            prev = 4'h0;
            exp_src = 4'h0;
        end else if (clk_en) begin
            exp_src = {fire(flags[3], prev[3], m2, 2'h0), fire(flags[2], prev[2], mask_one[2], {1'b0, m1[4]}),
                fire(flags[1], prev[1], mask_one[1], m1[3:2]), fire(flags[0], prev[0], mask_one[0], m1[1:0])};
            prev = flags;
            if (reg_wr.wr && reg_wr.index == mask_two_index) m2 = reg_wr.data[0];
            if (reg_wr.wr && reg_wr.index == mode_one_index) m1 = reg_wr.data[4:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare tasks count every check and report each mismatch.
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_evt(input string nm, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset, then random flags, masks, stalls, writes and reads each falling edge.
    initial begin
        seed = 77939;
        fails = 0;
        samples_checked = 0;
        clk_en = 1'b1;
        rst_b = 1'b0;
        mask_one = 3'h0;
        flags = '0;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) rst_b = 1'b1;
        repeat (4000) begin
            @(negedge ref_clk);
            chk_evt("src_active", exp_src, src_active);
            chk_evt("irq_out", {3'h0, |exp_src}, {3'h0, irq_out});
            flags = src_flags_t'(4'($random(seed)));
            mask_one = 3'($random(seed));
            clk_en = ($random(seed) & 7) != 0;
            wi = 8'h06 + 8'($random(seed) & 3);
            ri = 8'h06 + 8'($random(seed) & 3);
            i_host.put(($random(seed) & 3) == 0, wi, 8'($random(seed)), ri);
            #1 chk_reg("rd_data", rd_exp(rd_index), rd_data);
        end
        conclude();
    end
endmodule
